// *** rtl/dps_delay_loop.sv ***
// one delay loop: gray counter steered by the phase comparator, lock timer
`timescale 1ns/1ps
module dps_delay_loop import dps_pkg::*; (
   // clocks and resets
   input wire logic ref_clk,
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control from the system domain (levels)
   input wire logic hold_rst,
   input wire logic low_jitter,
   // comparator says the chain delay is too long
   input wire logic phase_late,
   // settings towards the system domain
   dps_loop_if.loop lp
);
   logic rrst;
   logic ljit;
   logic late;
   logic [SET_W-1:0] cnt_q, cnt_d;
   logic [SET_W-1:0] gray_q, gray_d;
   logic [LOCK_CNT_W-1:0] lock_q, lock_d;
   logic [1:0] div_q, div_d;
   logic locked_q, locked_d;
   logic [LOCK_CNT_W-1:0] lock_lim;

   // levels entering the reference domain
   dps_sync2 #(.W(3)) u_ref_sync (
      .clk(ref_clk),
      .rst(1'b0),
      .d({hold_rst, low_jitter, phase_late}),
      .q({rrst, ljit, late})
   );

   // lock period follows the jitter mode
   assign lock_lim = ljit ? LOCK_CNT_W'(LOCK_CYC_LOW_JITTER) : LOCK_CNT_W'(LOCK_CYC_NORMAL);

   // comparator steps the setting, lock timer counts reference cycles
   always_comb begin
      cnt_d = cnt_q;
      div_d = (ljit && div_q != UPD_DIV_LOW_JITTER) ? div_q + 2'h1 : 2'h0;
      lock_d = (lock_q < lock_lim) ? lock_q + LOCK_CNT_W'(1) : lock_q; // [RL3] [RL4]
      locked_d = lock_q >= lock_lim; // [RL25]
      if (div_d == 2'h0) begin // [RL1] [RL22]
         if (late && cnt_q != SET_RESET) begin
            cnt_d = cnt_q - SET_W'(1);
         end else if (!late && cnt_q != SET_TOP) begin
            cnt_d = cnt_q + SET_W'(1);
         end
      end
      gray_d = bin2gray(cnt_d); // [RL2]
   end

   always_ff @(posedge ref_clk) begin
      if (rrst) begin // [RL23]
         cnt_q <= SET_RESET;
         gray_q <= SET_RESET;
         lock_q <= '0;
         div_q <= 2'h0;
         locked_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         gray_q <= gray_d;
         lock_q <= lock_d;
         div_q <= div_d;
         locked_q <= locked_d;
      end
   end

   // gray word changes one bit per step, so bitwise sync is safe
   dps_sync2 #(.W(SET_W + 1)) u_sys_sync (
      .clk(sys_clk),
      .rst(sys_rst),
      .d({gray_q, locked_q}),
      .q({lp.setting_gray, lp.locked})
   );
endmodule

// *** rtl/dps_loop_if.sv ***
// settings and lock state carried from one delay loop to its user
`timescale 1ns/1ps
interface dps_loop_if import dps_pkg::*; ();
   logic [SET_W-1:0] setting_gray;
   logic locked;
   modport loop(output setting_gray, output locked);
   modport user(input setting_gray, input locked);
endinterface

// *** rtl/dps_phase_shift.sv ***
// strobe phase-shift top: two delay loops and per-group setting selection
// Function
// (RL1) Loop derives chain control from reference and tracks process, voltage, temperature.
// (RL2) Distributed delay settings are gray coded, one bit per update.
// (RL3) Low jitter mode locks within at most 1280 reference cycles.
// (RL4) Normal mode locks within 256 reference cycles.
// (RL5) Interface logic sends no read data through strobes before lock.
// (RL6) Consumers treat settings as invalid until the lock period elapses.
// (RL7) Usable below 100 MHz, shift capped at 2.5 ns.
// (RL8) Each loop locks to exactly one reference frequency.
// (RL9) Each loop has two outputs with independent phase offsets.
// (RL10) Each strobe group picks one of the two loop outputs.
// (RL11) All connected strobe groups take each update in the same cycle.
// (RL12) Two-loop part: each loop reaches top, bottom, right with identical settings.
// (RL13) Two-loop part: each bank uses either or both loops per group.
// (RL14) Four-loop part: each corner loop reaches only its two adjacent sides.
// (RL15) Four-loop part: banks pick either or both adjacent loops.
// (RL16) One loop may serve two same-frequency interfaces on adjacent sides.
// (RL17) Two-loop reference sources: first top pins or pll, second bottom/right pins or pll.
// (RL18) Four-loop reference: pll or dedicated pins on adjacent sides.
// (RL19) Shift applied to strobes only during reads.
// (RL20) Per-side fine adjustment is added to the shared shift.
// (RL21) Loop compares reference with delayed chain output through a comparator.
// (RL22) Up/down result steps a 6-bit gray counter until aligned.
// (RL23) Loop reset from core or user pin restarts the lock period.
// (RL24) Offsets reach strobe groups only; raw settings reach core and groups.
// (RL25) Lock indication rises after the mode's lock count, falls on reset.
`timescale 1ns/1ps
module dps_phase_shift import dps_pkg::*; #(
   parameter int NUM_GROUPS = 4,
   parameter bit FOUR_VARIANT = 1'b0,
   parameter int STEP_PS = 50
) (
   // system clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // reference clocks, one per loop (link domains)
   input wire logic REF_CLK_FIRST,
   input wire logic REF_CLK_SECOND,
   // phase comparator results from the delay chains
   input wire logic PHASE_LATE_FIRST,
   input wire logic PHASE_LATE_SECOND,
   // loop resets: core request and user pin
   input wire logic CORE_DLL_RESET,
   input wire logic USER_DLL_RESET,
   // loop configuration
   input wire logic [1:0] LOW_JITTER,
   input wire logic [1:0][REF_SEL_W-1:0] REF_SEL,
   input wire logic [1:0][1:0][OFS_W-1:0] OUT_OFFSET,
   input wire logic [3:0][FINE_W-1:0] SIDE_FINE,
   // strobe group configuration and read activity
   input wire logic [NUM_GROUPS-1:0] GROUP_LOOP_SEL,
   input wire logic [NUM_GROUPS-1:0] GROUP_OUT_SEL,
   input wire logic [NUM_GROUPS-1:0][1:0] GROUP_SIDE,
   input wire logic [NUM_GROUPS-1:0] READ_ACTIVE,
   // settings to the core and lock status
   output logic [1:0][SET_W-1:0] CORE_DELAY,
   output logic [1:0] LOCKED,
   output logic [1:0] REF_SEL_ERR,
   // settings to the strobe groups
   output logic [NUM_GROUPS-1:0][SET_W-1:0] GROUP_DELAY,
   output logic [NUM_GROUPS-1:0] GROUP_SHIFT_EN,
   output logic [NUM_GROUPS-1:0] GROUP_REACH_ERR
);
   // largest code allowed by the shift ceiling
   localparam int MAX_CODE_RAW = MAX_SHIFT_PS / STEP_PS;
   localparam logic [SET_W-1:0] MAX_CODE =
      (MAX_CODE_RAW > 63) ? SET_TOP : SET_W'(MAX_CODE_RAW);

   logic user_rst_s;
   logic [1:0] ref_ok;
   logic [1:0] hold_q, hold_d;
   logic [1:0] req;
   logic [1:0][HOLD_CNT_W-1:0] hcnt_q, hcnt_d;
   logic [1:0] stale_q, stale_d;
   logic [1:0] late_pin;
   logic [1:0][SET_W-1:0] set_gray;
   logic [1:0][SET_W-1:0] set_bin;
   logic [1:0] set_locked;
   logic [1:0][SET_W-1:0] core_q, core_d;
   logic [1:0] locked_q, locked_d;
   logic [1:0] ref_err_q, ref_err_d;
   logic [NUM_GROUPS-1:0][SET_W-1:0] gdel_q, gdel_d;
   logic [NUM_GROUPS-1:0] gen_q, gen_d;
   logic [NUM_GROUPS-1:0] gerr_q, gerr_d;

   // clamp a signed sum into the usable code range
   function automatic logic [SET_W-1:0] clamp_code(input logic signed [SUM_W-1:0] s);
      if (s < 0) begin
         return SET_RESET;
      end
      if (s > $signed({3'h0, MAX_CODE})) begin
         return MAX_CODE; // [RL7]
      end
      return s[SET_W-1:0];
   endfunction

   // sign-extend an output offset to the sum width
   function automatic logic signed [SUM_W-1:0] ext_ofs(input logic [OFS_W-1:0] v);
      return $signed({{(SUM_W - OFS_W){v[OFS_W-1]}}, v});
   endfunction

   // sign-extend a side fine adjustment to the sum width
   function automatic logic signed [SUM_W-1:0] ext_fine(input logic [FINE_W-1:0] v);
      return $signed({{(SUM_W - FINE_W){v[FINE_W-1]}}, v});
   endfunction

   // user reset pin is asynchronous to the system clock
   dps_sync2 #(.W(1)) u_pin_sync (
      .clk(SYS_CLK),
      .rst(RESET),
      .d(USER_DLL_RESET),
      .q(user_rst_s)
   );

   // reference source legality per loop
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ref_ok[i] = ref_legal(FOUR_VARIANT, i[0], REF_SEL[i]); // [RL17] [RL18]
      end
   end

   // loop reset request: core, pin, or illegal reference choice
   // stretched so a short request still spans two reference edges
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         req[i] = CORE_DLL_RESET | user_rst_s | ~ref_ok[i]; // [RL23]
         hcnt_d[i] = req[i] ? HOLD_CNT_W'(HOLD_STRETCH) :
            ((hcnt_q[i] != '0) ? hcnt_q[i] - HOLD_CNT_W'(1) : hcnt_q[i]);
         hold_d[i] = req[i] | (hcnt_q[i] != '0);
         // lock stays down until the loop is seen restarting; set wins
         stale_d[i] = hold_q[i] | (stale_q[i] & set_locked[i]); // [RL25]
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         hold_q <= 2'h3;
         hcnt_q <= {2{HOLD_CNT_W'(HOLD_STRETCH)}};
         stale_q <= 2'h3;
      end else begin
         hold_q <= hold_d;
         hcnt_q <= hcnt_d;
         stale_q <= stale_d;
      end
   end

   assign late_pin = {PHASE_LATE_SECOND, PHASE_LATE_FIRST};

   // each loop runs on its own single reference frequency
   dps_loop_if loop_if[2] ();

   dps_delay_loop u_loop_first ( // [RL8] [RL21]
      .ref_clk(REF_CLK_FIRST),
      .sys_clk(SYS_CLK),
      .sys_rst(RESET),
      .hold_rst(hold_q[0]),
      .low_jitter(LOW_JITTER[0]),
      .phase_late(late_pin[0]),
      .lp(loop_if[0])
   );

   dps_delay_loop u_loop_second ( // [RL8] [RL21]
      .ref_clk(REF_CLK_SECOND),
      .sys_clk(SYS_CLK),
      .sys_rst(RESET),
      .hold_rst(hold_q[1]),
      .low_jitter(LOW_JITTER[1]),
      .phase_late(late_pin[1]),
      .lp(loop_if[1])
   );

   // unpack interface contents into indexable arrays
   assign set_gray[0] = loop_if[0].setting_gray;
   assign set_gray[1] = loop_if[1].setting_gray;
   assign set_locked[0] = loop_if[0].locked;
   assign set_locked[1] = loop_if[1].locked;

   // binary form for offset arithmetic
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         set_bin[i] = gray2bin(set_gray[i]);
      end
   end

   // core sees raw settings without offsets, plus lock and config status
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         core_d[i] = set_gray[i]; // [RL24]
         locked_d[i] = set_locked[i] & ~hold_q[i] & ~stale_q[i]; // [RL25]
         ref_err_d[i] = ~ref_ok[i];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         core_q <= '0;
         locked_q <= 2'h0;
         ref_err_q <= 2'h0;
      end else begin
         core_q <= core_d;
         locked_q <= locked_d;
         ref_err_q <= ref_err_d;
      end
   end

   // per-group selection of loop, output and side adjustment
   always_comb begin
      logic li;
      logic oi;
      dps_side_t sd;
      logic reach;
      logic signed [SUM_W-1:0] sum;
      li = 1'b0;
      oi = 1'b0;
      sd = SIDE_TOP;
      reach = 1'b0;
      sum = '0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         li = GROUP_LOOP_SEL[g]; // [RL13] [RL15] [RL16]
         oi = GROUP_OUT_SEL[g]; // [RL10]
         sd = dps_side_t'(GROUP_SIDE[g]);
         reach = side_reach(FOUR_VARIANT, li, sd); // [RL12] [RL14]
         sum = $signed({3'h0, set_bin[li]})
               + ext_ofs(OUT_OFFSET[li][oi]) // [RL9]
               + ext_fine(SIDE_FINE[sd]); // [RL20]
         gdel_d[g] = bin2gray(clamp_code(sum)); // [RL2] [RL24]
         gen_d[g] = READ_ACTIVE[g] & locked_q[li] & reach; // [RL19] [RL5] [RL6]
         gerr_d[g] = ~reach;
      end
   end

   // every group register loads in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         gdel_q <= '0;
         gen_q <= '0;
         gerr_q <= '0;
      end else begin
         gdel_q <= gdel_d; // [RL11]
         gen_q <= gen_d;
         gerr_q <= gerr_d;
      end
   end

   // outputs straight from flops
   assign CORE_DELAY = core_q;
   assign LOCKED = locked_q;
   assign REF_SEL_ERR = ref_err_q;
   assign GROUP_DELAY = gdel_q;
   assign GROUP_SHIFT_EN = gen_q;
   assign GROUP_REACH_ERR = gerr_q;
endmodule

// *** rtl/dps_pkg.sv ***
// shared constants, types and helpers for the strobe phase-shift block
package dps_pkg;
   // delay setting and delay chain
   localparam int SET_W = 6;
   localparam int CHAIN_LEN = 16;
   localparam logic [SET_W-1:0] SET_RESET = 6'h00;
   localparam logic [SET_W-1:0] SET_TOP = 6'h3f;
   // lock periods in reference clock cycles
   localparam int LOCK_CYC_LOW_JITTER = 1280;
   localparam int LOCK_CYC_NORMAL = 256;
   localparam int LOCK_CNT_W = 11;
   // system cycles a loop reset request is stretched; must span two reference edges
   localparam int HOLD_STRETCH = 32;
   localparam int HOLD_CNT_W = 6;
   // last divider count in low jitter mode; settings update every 4 reference cycles
   localparam logic [1:0] UPD_DIV_LOW_JITTER = 2'h3;
   // strobe shift ceiling for slow interfaces, in picoseconds
   localparam int MAX_SHIFT_PS = 2500;
   // reference select code: bit 3 picks the loop's pll, else pin index
   localparam int REF_SEL_W = 4;
   localparam int REF_PLL_BIT = 3;
   localparam int REF_PINS_FIRST = 4;
   localparam int REF_PINS_SECOND = 8;
   // offset widths
   localparam int OFS_W = 6;
   localparam int FINE_W = 4;
   localparam int SUM_W = 9;

   typedef enum logic [1:0] {SIDE_TOP, SIDE_BOTTOM, SIDE_RIGHT, SIDE_LEFT} dps_side_t;

   function automatic logic [SET_W-1:0] bin2gray(input logic [SET_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [SET_W-1:0] gray2bin(input logic [SET_W-1:0] g);
      logic [SET_W-1:0] b;
      b[SET_W-1] = g[SET_W-1];
      for (int i = SET_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // which sides a loop reaches: loop 0 top-left, loop 1 bottom-left (four-loop part)
   function automatic logic side_reach(input logic four, input logic loop, input dps_side_t s);
      if (!four) begin
         return s != SIDE_LEFT;
      end
      return (s == SIDE_LEFT) || (loop ? (s == SIDE_BOTTOM) : (s == SIDE_TOP));
   endfunction

   // legal reference source for a loop
   function automatic logic ref_legal(input logic four, input logic loop,
                                      input logic [REF_SEL_W-1:0] sel);
      if (sel[REF_PLL_BIT] || four) begin
         return 1'b1;
      end
      return loop ? (32'(sel) < REF_PINS_SECOND) : (32'(sel) < REF_PINS_FIRST);
   endfunction
endpackage

// *** rtl/dps_sync2.sv ***
// two-flop level synchroniser
`timescale 1ns/1ps
module dps_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // first stage feeds only the second
   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule

// *** test/dps_chain_model.sv ***
// delay chain and phase comparator model facing one loop
`timescale 1ns/1ps
module dps_chain_model import dps_pkg::*; (
   // reference and setting in use
   input wire logic ref_clk,
   input wire logic [SET_W-1:0] setting_gray,
   input wire logic [SET_W-1:0] target,
   // comparator verdict
   output logic phase_late
);
   logic [SET_W-1:0] steps;
   initial phase_late = 1'b0;
   // late once the chain is longer than the target step count
   always @(posedge ref_clk) begin
      for (int i = 0; i < SET_W; i++) steps[i] = ^(setting_gray >> i);
      phase_late <= (steps > target);
   end
endmodule

// *** test/dps_phase_shift_asserts.sv ***
// assertion checker for the strobe phase-shift top
`timescale 1ns/1ps
module dps_phase_shift_asserts import dps_pkg::*; #(
   parameter int NUM_GROUPS = 4,
   parameter bit FOUR_VARIANT = 1'b0,
   parameter int STEP_PS = 50
) (
   // clock, reset, controls
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic CORE_DLL_RESET,
   input wire logic USER_DLL_RESET,
   input wire logic [1:0] LOW_JITTER,
   input wire logic [NUM_GROUPS-1:0][1:0] GROUP_SIDE,
   input wire logic [NUM_GROUPS-1:0] READ_ACTIVE,
   // outputs watched
   input wire logic [1:0][SET_W-1:0] CORE_DELAY,
   input wire logic [1:0] LOCKED,
   input wire logic [1:0] REF_SEL_ERR,
   input wire logic [NUM_GROUPS-1:0][SET_W-1:0] GROUP_DELAY,
   input wire logic [NUM_GROUPS-1:0] GROUP_SHIFT_EN,
   input wire logic [NUM_GROUPS-1:0] GROUP_REACH_ERR
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   logic [1:0][14:0] cyc_q, cyc_d;
   function automatic logic [SET_W-1:0] ungray(input logic [SET_W-1:0] g);
      for (int i = 0; i < SET_W; i++) ungray[i] = ^(g >> i);
   endfunction
   sequence s_unlock(lk);
      ##[0:80] !lk;
   endsequence
   // cycles since last loop reset, saturating
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         cyc_d[l] = (CORE_DLL_RESET || USER_DLL_RESET || REF_SEL_ERR[l]) ? 15'h0 :
            cyc_q[l] + 15'(cyc_q[l] != 15'h7fff);
      end
   end
   always_ff @(posedge SYS_CLK) begin
      cyc_q <= RESET ? '0 : cyc_d;
   end
   // lock timing, loss and gray setting steps per loop
   for (genvar l = 0; l < 2; l++) begin : g_loop
      a_lock_not_early: assert property ($rose(LOCKED[l]) |->
         cyc_q[l] >= (LOW_JITTER[l] ? 15'h3c00 : 15'hc00)) else $error("lock too early");
      a_lock_in_time: assert property (!REF_SEL_ERR[l] &&
         cyc_q[l] == (LOW_JITTER[l] ? 15'h4128 : 15'hd28) |-> LOCKED[l])
         else $error("lock too late");
      a_reset_holds: assert property (CORE_DLL_RESET [*2] |=> !LOCKED[l])
         else $error("locked during loop reset");
      a_err_unlocks: assert property ($rose(REF_SEL_ERR[l]) |-> s_unlock(LOCKED[l]))
         else $error("illegal source kept lock");
      a_gray_step: assert property (LOCKED[l] && $past(LOCKED[l]) |->
         $countones(CORE_DELAY[l] ^ $past(CORE_DELAY[l])) <= 1) else $error("multi-bit step");
   end
   // per-group routing
   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
      a_shift_on_read: assert property (GROUP_SHIFT_EN[g] |->
         $past(READ_ACTIVE[g]) && !GROUP_REACH_ERR[g]) else $error("shift without read");
      a_reach_sides: assert property (!FOUR_VARIANT && !$past(RESET) |->
         GROUP_REACH_ERR[g] == ($past(GROUP_SIDE[g]) == 2'h3)) else $error("reach flag");
      a_delay_capped: assert property (
         ungray(GROUP_DELAY[g]) <= 6'(MAX_SHIFT_PS / STEP_PS)) else $error("shift cap");
   end
   a_no_early_shift: assert property ((LOCKED == 2'h0) [*4] |->
      $past(GROUP_SHIFT_EN, 2) == '0) else $error("shift before lock");
endmodule
bind dps_phase_shift dps_phase_shift_asserts #(.NUM_GROUPS(NUM_GROUPS),
   .FOUR_VARIANT(FOUR_VARIANT), .STEP_PS(STEP_PS)) u_asserts (.SYS_CLK, .RESET,
   .CORE_DLL_RESET, .USER_DLL_RESET, .LOW_JITTER, .GROUP_SIDE, .READ_ACTIVE, .CORE_DELAY,
   .LOCKED, .REF_SEL_ERR, .GROUP_DELAY, .GROUP_SHIFT_EN, .GROUP_REACH_ERR);

// *** test/dps_phase_shift_test.sv ***
// self-checking bench for the strobe phase-shift top
`timescale 1ns/1ps
module dps_phase_shift_test import dps_pkg::*; ();
   localparam int STEP = 50;
   localparam int CAP = MAX_SHIFT_PS / STEP;
   logic SYS_CLK, RESET, REF_CLK_FIRST, REF_CLK_SECOND, PHASE_LATE_FIRST, PHASE_LATE_SECOND;
   logic CORE_DLL_RESET, USER_DLL_RESET;
   logic [1:0] LOW_JITTER, LOCKED, REF_SEL_ERR;
   logic [1:0][REF_SEL_W-1:0] REF_SEL;
   logic [1:0][1:0][OFS_W-1:0] OUT_OFFSET;
   logic [3:0][FINE_W-1:0] SIDE_FINE;
   logic [3:0] GROUP_LOOP_SEL, GROUP_OUT_SEL, READ_ACTIVE, GROUP_SHIFT_EN, GROUP_REACH_ERR;
   logic [3:0][1:0] GROUP_SIDE;
   logic [1:0][SET_W-1:0] CORE_DELAY;
   logic [3:0][SET_W-1:0] GROUP_DELAY;
   logic [SET_W-1:0] tgt0 = 6'h14;
   int n_mismatch = 0;
   int total_checks = 0;
   dps_phase_shift #(.NUM_GROUPS(4), .STEP_PS(STEP)) DUT (.SYS_CLK, .RESET, .REF_CLK_FIRST,
      .REF_CLK_SECOND, .PHASE_LATE_FIRST, .PHASE_LATE_SECOND, .CORE_DLL_RESET,
      .USER_DLL_RESET, .LOW_JITTER, .REF_SEL, .OUT_OFFSET, .SIDE_FINE, .GROUP_LOOP_SEL,
      .GROUP_OUT_SEL, .GROUP_SIDE, .READ_ACTIVE, .CORE_DELAY, .LOCKED, .REF_SEL_ERR,
      .GROUP_DELAY, .GROUP_SHIFT_EN, .GROUP_REACH_ERR);
   // chains: first tracks a random target, second saturates high
   dps_chain_model P0 (.ref_clk(REF_CLK_FIRST), .setting_gray(CORE_DELAY[0]), .target(tgt0),
      .phase_late(PHASE_LATE_FIRST));
   dps_chain_model P1 (.ref_clk(REF_CLK_SECOND), .setting_gray(CORE_DELAY[1]),
      .target(6'h3f), .phase_late(PHASE_LATE_SECOND));
   // system clock and two reference clocks of equal period, offset in phase
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      REF_CLK_FIRST = 1'b0;
      #3.3;
      forever #62.5 REF_CLK_FIRST = ~REF_CLK_FIRST;
   end
   initial begin
      REF_CLK_SECOND = 1'b0;
      #41.7;
      forever #62.5 REF_CLK_SECOND = ~REF_CLK_SECOND;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic stop_run(input string m);
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
      tally_and_finish();
   endtask
   task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic chk_set(input logic [5:0] got, input logic [5:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   function automatic logic [SET_W-1:0] dec(input logic [SET_W-1:0] g);
      for (int i = 0; i < SET_W; i++) dec[i] = ^(g >> i);
   endfunction
   // raw step (first loop as seen, second saturated) plus offset and trim, clamped
   function automatic logic [SET_W-1:0] exp_delay(input int g);
      int s;
      logic l;
      l = GROUP_LOOP_SEL[g];
      s = l ? 63 : int'(dec(CORE_DELAY[0]));
      s = s + int'($signed(OUT_OFFSET[l][GROUP_OUT_SEL[g]]));
      s = s + int'($signed(SIDE_FINE[GROUP_SIDE[g]]));
      s = (s < 0) ? 0 : ((s > CAP) ? CAP : s);
      return 6'(s) ^ (6'(s) >> 1);
   endfunction
   // wait for three quiet cycles of the raw settings
   task automatic settle();
      logic [1:0][SET_W-1:0] prev;
      int k;
      k = 0;
      prev = CORE_DELAY;
      for (int i = 0; i < 200 && k < 3; i++) begin
         @(posedge SYS_CLK);
         #2;
         k = (CORE_DELAY === prev) ? k + 1 : 0;
         prev = CORE_DELAY;
      end
      if (k < 3) stop_run("settings never steady");
   endtask
   task automatic rand_groups(input int n);
      logic [3:0] far;
      for (int i = 0; i < n; i++) begin
         @(posedge SYS_CLK);
         #1;
         GROUP_LOOP_SEL = 4'($urandom);
         GROUP_OUT_SEL = 4'($urandom);
         GROUP_SIDE = 8'($urandom);
         READ_ACTIVE = 4'($urandom);
         OUT_OFFSET = (i == 0) ? {4{6'h20}} : ((i == 1) ? {4{6'h1f}} : 24'($urandom));
         SIDE_FINE = (i == 0) ? {4{4'h8}} : ((i == 1) ? {4{4'h7}} : 16'($urandom));
         settle();
         for (int g = 0; g < 4; g++) begin
            far[g] = (GROUP_SIDE[g] == 2'h3);
            if (!far[g]) chk_set(GROUP_DELAY[g], exp_delay(g), "group delay");
         end
         chk_set(CORE_DELAY[1], 6'h20, "raw setting");
         chk_flags(4'(dec(CORE_DELAY[0]) + 6'h6 - tgt0 <= 6'hc), 4'h1, "tracking");
         chk_flags(GROUP_REACH_ERR, far, "reach flag");
         chk_flags(GROUP_SHIFT_EN, READ_ACTIVE & ~far, "shift enable");
      end
      $display("done: %0d routing draws", n);
   endtask
   task automatic ref_table();
      for (int v = 0; v < 16; v++) begin
         @(posedge SYS_CLK);
         #1;
         REF_SEL = {4'(v), 4'(v)};
         repeat (3) @(posedge SYS_CLK);
         chk_flags(4'(REF_SEL_ERR), 4'(v > 3 && v < 8), "source check");
      end
      REF_SEL = {4'h8, 4'h0};
      $display("done: reference sources");
   endtask
   task automatic relock(input logic lj, input logic pin);
      int c;
      int n;
      n = lj ? 1280 : 256;
      @(posedge SYS_CLK);
      #1;
      LOW_JITTER = {lj, lj};
      CORE_DLL_RESET = !pin;
      USER_DLL_RESET = pin;
      READ_ACTIVE = 4'hf;
      repeat (40) @(posedge SYS_CLK);
      #1;
      chk_flags(4'(LOCKED), 4'h0, "lock in reset");
      CORE_DLL_RESET = 1'b0;
      USER_DLL_RESET = 1'b0;
      c = 0;
      while (LOCKED !== 2'h3 && c < 20000) begin
         @(posedge SYS_CLK);
         #2;
         c++;
         if (c == 100) chk_flags(GROUP_SHIFT_EN, 4'h0, "early shift");
      end
      if (c == 20000) stop_run("no lock");
      chk_flags(4'(c >= n * 12 && c <= n * 13 + 40), 4'h1, "lock time");
      $display("done: relock mode %0d pin %0d in %0d cycles", lj, pin, c);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'hbb6c7418));
      RESET = 1'b1;
      CORE_DLL_RESET = 1'b0;
      USER_DLL_RESET = 1'b0;
      LOW_JITTER = 2'h0;
      REF_SEL = {4'h3, 4'h8};
      OUT_OFFSET = '0;
      SIDE_FINE = '0;
      GROUP_LOOP_SEL = 4'h0;
      GROUP_OUT_SEL = 4'h0;
      GROUP_SIDE = '0;
      READ_ACTIVE = 4'h0;
      tgt0 = 6'(10 + $urandom % 30);
      repeat (8) @(posedge SYS_CLK);
      #1;
      RESET = 1'b0;
      relock(1'b0, 1'b0);
      settle();
      // sync latency in the loop makes it dither a few steps around the target
      chk_flags(4'(dec(CORE_DELAY[0]) + 6'h6 - tgt0 <= 6'hc), 4'h1, "tracking");
      rand_groups(30);
      ref_table();
      relock(1'b1, 1'b1);
      rand_groups(8);
      relock(1'b0, 1'b1);
      tally_and_finish();
   end
endmodule
